// *** rtl/fted_top.sv ***
// Fan tach measurement: edge counting, stall/slow classification, stretch.
`timescale 1ns/10ps
module fted_top
    import fted_pkg::*;
#(
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        fan_speed_input_n,
    input  wire logic        pwm_on,
    input  wire logic        update_start,
    input  wire logic        mode_sync,
    input  wire logic        opt_ignore3,
    input  wire logic        opt_slow_sel,
    input  wire logic [1:0]  opt_edges,
    input  wire logic [1:0]  opt_guard,
    input  wire logic [2:0]  opt_stretch,
    output logic      [15:0] reading_q,
    output logic             stalled_q,
    output logic             slow_q,
    output logic             done_q,
    output logic             stretch_q,
    output logic             busy_q
);

    // ------------------------------------------------------------------
    // Tick and edge detection
    // ------------------------------------------------------------------
    logic tick_w;

    fted_tick_gen #(
        .DIV     (TICK_DIV)
    ) u_tick (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .tick_q  (tick_w)
    );

    fted_state_e state_q;
    fted_state_e state_d;
    logic        fan_prev_q;
    logic [5:0]  guard_cnt_q;
    logic [16:0] win_cnt_q;
    logic [15:0] meas_cnt_q;
    logic [3:0]  edge_cnt_q;
    logic [1:0]  ign_cnt_q;
    logic        running_q;

    logic        edge_w;
    logic        ign_active_w;
    logic        counted_edge_w;
    logic [5:0]  guard_lim_w;
    logic [3:0]  edges_need_w;
    logic [16:0] stretch_lim_w;
    logic        stretch_on_w;
    logic        guard_end_w;
    logic        meas_sat_w;
    logic        win_end_w;
    logic        done_edges_w;
    logic        timeout_w;
    logic        finish_w;
    logic        in_meas_w;
    logic        cnt_tick_w;
    logic [15:0] result_w;

    assign edge_w        = fan_speed_input_n ^ fan_prev_q;
    assign in_meas_w     = (state_q == FTED_MEAS);
    assign guard_lim_w   = GUARD_TICKS[opt_guard];
    assign edges_need_w  = EDGE_COUNT[opt_edges];
    assign stretch_lim_w = stretch_ticks(opt_stretch);
    assign stretch_on_w  = (opt_stretch != STRETCH_OFF);

    // Edges are only dropped in the synced mode and only up to three.
    assign ign_active_w   = mode_sync && opt_ignore3
                            && (ign_cnt_q != IGNORE_EDGES);
    assign counted_edge_w = in_meas_w && edge_w && !ign_active_w;

    assign guard_end_w = tick_w && (guard_cnt_q == guard_lim_w - 6'h01);
    assign meas_sat_w  = running_q && (meas_cnt_q == CNT_MAX);
    // The tick in the cycle of the first counted edge is counted, so the
    // reading is the tick count from first to last edge, whatever the phase.
    assign cnt_tick_w  = tick_w && (running_q || counted_edge_w)
                         && !meas_sat_w;

    // In synced mode without stretch the window is the PWM on-time; since full duty still
    // drops low once per period, every window is bounded.
    assign win_end_w = mode_sync
        ? (stretch_on_w ? (win_cnt_q >= stretch_lim_w)
                        : !pwm_on)
        : (win_cnt_q >= {1'b0, CNT_MAX});

    assign done_edges_w = counted_edge_w
                          && (edge_cnt_q == edges_need_w - 4'h1);
    assign timeout_w    = in_meas_w && (win_end_w || meas_sat_w);
    // Final edge wins over a timeout in the same cycle.
    assign finish_w     = done_edges_w || timeout_w;

    // A latched count equal to FFFFh reads as a stall naturally.
    assign result_w = done_edges_w ? meas_cnt_q
                    : (edge_cnt_q == 4'h0) ? READ_STALL
                    : opt_slow_sel ? READ_STALL
                    : READ_SLOW;

    // ------------------------------------------------------------------
    // State machine
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            FTED_IDLE: begin
                if (!mode_sync) begin
                    state_d = FTED_MEAS;
                end else if (update_start) begin
                    state_d = FTED_WAITP;
                end
            end
            FTED_WAITP: begin
                if (!mode_sync) begin
                    state_d = FTED_IDLE;
                end else if (pwm_on) begin
                    state_d = FTED_GUARD;
                end
            end
            FTED_GUARD: begin
                if (!mode_sync) begin
                    state_d = FTED_IDLE;
                end else if (guard_end_w) begin
                    state_d = FTED_MEAS;
                end
            end
            FTED_MEAS: begin
                if (finish_w) begin
                    state_d = FTED_IDLE;
                end
            end
            default: state_d = FTED_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= FTED_IDLE;
            fan_prev_q <= 1'b1;
        end else begin
            state_q    <= state_d;
            fan_prev_q <= fan_speed_input_n;
        end
    end

    // ------------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_cnt_q <= 6'h00;
        end else if (state_q != FTED_GUARD) begin
            guard_cnt_q <= 6'h00;
        end else if (tick_w) begin
            guard_cnt_q <= guard_cnt_q + 6'h01;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            win_cnt_q  <= 17'h00000;
            meas_cnt_q <= 16'h0000;
            edge_cnt_q <= 4'h0;
            ign_cnt_q  <= 2'h0;
            running_q  <= 1'b0;
        end else if (!in_meas_w || finish_w) begin
            win_cnt_q  <= 17'h00000;
            meas_cnt_q <= 16'h0000;
            edge_cnt_q <= 4'h0;
            ign_cnt_q  <= 2'h0;
            running_q  <= 1'b0;
        end else begin
            if (tick_w && win_cnt_q != 17'h1FFFF) begin
                win_cnt_q <= win_cnt_q + 17'h00001;
            end
            if (cnt_tick_w) begin
                meas_cnt_q <= meas_cnt_q + 16'h0001;
            end
            if (edge_w && ign_active_w) begin
                ign_cnt_q <= ign_cnt_q + 2'h1;
            end
            if (counted_edge_w) begin
                edge_cnt_q <= edge_cnt_q + 4'h1;
                running_q  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            reading_q <= READ_RESET;
            stalled_q <= 1'b0;
            slow_q    <= 1'b0;
            done_q    <= 1'b0;
            stretch_q <= 1'b0;
            busy_q    <= 1'b0;
        end else begin
            done_q    <= finish_w;
            busy_q    <= (state_d == FTED_GUARD) || (state_d == FTED_MEAS);
            // Stretch is released on the clock after the final edge lands, together with done.
            stretch_q <= mode_sync && stretch_on_w && !finish_w
                         && ((state_q == FTED_GUARD && pwm_on)
                             || in_meas_w);
            if (finish_w) begin
                reading_q <= result_w;
                stalled_q <= !done_edges_w && (edge_cnt_q == 4'h0);
                slow_q    <= !done_edges_w && (edge_cnt_q != 4'h0);
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_stall_end;
        timeout_w && !done_edges_w && edge_cnt_q == 4'h0;
    endsequence

    sequence s_slow_end;
        timeout_w && !done_edges_w && edge_cnt_q != 4'h0;
    endsequence

    property p_stall_reads_ffff;
        @(posedge ref_clk) disable iff (!reset_n)
        s_stall_end |=> reading_q == READ_STALL && stalled_q;
    endproperty
    a_stall_reads_ffff: assert property (p_stall_reads_ffff)
        else $error("stall did not load FFFFh");

    property p_slow_sel0;
        @(posedge ref_clk) disable iff (!reset_n)
        s_slow_end and !opt_slow_sel |=> reading_q == READ_SLOW && slow_q;
    endproperty
    a_slow_sel0: assert property (p_slow_sel0)
        else $error("slow with select 0 gave wrong value");

    property p_slow_sel1;
        @(posedge ref_clk) disable iff (!reset_n)
        s_slow_end and opt_slow_sel |=> reading_q == READ_STALL && slow_q;
    endproperty
    a_slow_sel1: assert property (p_slow_sel1)
        else $error("slow with select 1 gave wrong value");

    property p_sat_is_slow;
        @(posedge ref_clk) disable iff (!reset_n)
        in_meas_w && meas_sat_w && !done_edges_w |=> slow_q && done_q;
    endproperty
    a_sat_is_slow: assert property (p_sat_is_slow)
        else $error("saturated counter not treated as slow");

    property p_done_latches;
        @(posedge ref_clk) disable iff (!reset_n)
        done_edges_w |=> reading_q == $past(meas_cnt_q)
                         && !slow_q && !stalled_q;
    endproperty
    a_done_latches: assert property (p_done_latches)
        else $error("final edge did not latch the count");

    property p_stretch_drop;
        @(posedge ref_clk) disable iff (!reset_n)
        done_edges_w |=> !stretch_q ##1 !stretch_q;
    endproperty
    a_stretch_drop: assert property (p_stretch_drop)
        else $error("stretch not ended on final edge");

    property p_done_resets;
        @(posedge ref_clk) disable iff (!reset_n)
        finish_w |=> state_q == FTED_IDLE && edge_cnt_q == 4'h0
                     && meas_cnt_q == 16'h0000;
    endproperty
    a_done_resets: assert property (p_done_resets)
        else $error("machine not reset after measurement");

    property p_cnt_saturates;
        @(posedge ref_clk) disable iff (!reset_n)
        in_meas_w && tick_w && running_q && !finish_w
        |=> meas_cnt_q == $past(meas_cnt_q) + 16'h0001
            && meas_cnt_q != 16'h0000;
    endproperty
    a_cnt_saturates: assert property (p_cnt_saturates)
        else $error("measurement counter wrapped");

    property p_ignored_edge;
        @(posedge ref_clk) disable iff (!reset_n)
        in_meas_w && edge_w && ign_active_w && !finish_w
        |=> $stable(edge_cnt_q) && !running_q == !$past(running_q);
    endproperty
    a_ignored_edge: assert property (p_ignored_edge)
        else $error("ignored edge was counted");

    property p_guard_len;
        @(posedge ref_clk) disable iff (!reset_n)
        state_q == FTED_WAITP && state_d == FTED_GUARD
        |=> (state_q == FTED_GUARD) [*8];
    endproperty
    a_guard_len: assert property (p_guard_len)
        else $error("guard shorter than minimum");

endmodule : fted_top

// *** rtl/fted_pkg.sv ***
// Shared constants for the fan tach edge-detect measurement block.
package fted_pkg;

    // ------------------------------------------------------------------
    // Clocking
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned MEAS_HZ     = 90_000;
    // Nearest whole divide; the 90 kHz tick is nominal anyway.
    localparam int unsigned TICK_CYCLES = (CLK_HZ + MEAS_HZ / 2) / MEAS_HZ;

    // ------------------------------------------------------------------
    // Readings and counter limits
    // ------------------------------------------------------------------
    localparam logic [15:0] READ_STALL  = 16'hFFFF;
    localparam logic [15:0] READ_SLOW   = 16'hFFFE;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [15:0] READ_RESET  = 16'h0000;
    localparam logic [1:0]  IGNORE_EDGES = 2'h3;

    // ------------------------------------------------------------------
    // Guard time in 90 kHz ticks, per two-bit option code
    // ------------------------------------------------------------------
    localparam real         GUARD_MIN_US    = 88.88;
    localparam logic [5:0]  GUARD_TICKS [4] = '{6'h08, 6'h10, 6'h20, 6'h3F};

    // ------------------------------------------------------------------
    // Edges per measurement, per two-bit option code
    // ------------------------------------------------------------------
    localparam logic [3:0]  EDGE_COUNT [4] = '{4'h2, 4'h3, 4'h5, 4'h9};

    // ------------------------------------------------------------------
    // Stretch time in ms per three-bit code; code 0 disables stretching
    // ------------------------------------------------------------------
    localparam int unsigned STRETCH_MS [8] =
        '{0, 50, 100, 200, 400, 600, 800, 950};
    localparam logic [2:0]  STRETCH_OFF = 3'h0;

    function automatic logic [16:0] stretch_ticks(input logic [2:0] code);
        stretch_ticks = 17'(STRETCH_MS[code] * (MEAS_HZ / 1000));
    endfunction : stretch_ticks

    // ------------------------------------------------------------------
    // Measurement states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        FTED_IDLE  = 4'b0001,
        FTED_WAITP = 4'b0010,
        FTED_GUARD = 4'b0100,
        FTED_MEAS  = 4'b1000
    } fted_state_e;

endpackage : fted_pkg

// *** rtl/fted_tick_gen.sv ***
// Divider that turns the core clock into a one-cycle measurement tick.
`timescale 1ns/10ps
module fted_tick_gen #(
    parameter int unsigned DIV = 2778
) (
    input  wire logic ref_clk,
    input  wire logic reset_n,
    output logic      tick_q
);
    logic [15:0] div_q;
    logic        wrap_w;

    assign wrap_w = (div_q == 16'(DIV - 1));

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else begin
            div_q  <= wrap_w ? 16'h0000 : div_q + 16'h0001;
            tick_q <= wrap_w;
        end
    end

endmodule : fted_tick_gen

// *** sim/fted_fan_model.sv ***
// Behavioural fan whose tach output toggles while powered and spinning.
`timescale 1ns/10ps
module fted_fan_model (
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic        powered,
    input  wire logic        spinning,
    input  wire logic [15:0] period,
    output logic             tach
);
    logic [15:0] cnt_q;
    logic        lvl_q;

    // An unpowered fan leaves the open-collector tach at the pull-up level.
    assign tach = powered ? lvl_q : 1'b1;

    // A stopped fan parks high, so stopping never fakes an edge later.
    always @(negedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q <= 16'h0000;
            lvl_q <= 1'b1;
        end else if (cnt_q >= period - 16'h0001) begin
            cnt_q <= 16'h0000;
            lvl_q <= spinning ? !lvl_q : 1'b1;
        end else begin
            cnt_q <= cnt_q + 16'h0001;
        end
    end
endmodule : fted_fan_model

// *** sim/test_fted_top.sv ***
// Self-checking bench for the fan tach measurement block.
`timescale 1ns/10ps
module test_fted_top;
    import fted_pkg::*;
    localparam int DIV = 8;
    localparam int PER = 64;
    localparam int CYC_LIMIT = 90000;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        tach;
    logic        pwm_on = 1'b0;
    logic        update_start = 1'b0;
    logic        mode_sync = 1'b1;
    logic        opt_ignore3 = 1'b0;
    logic        opt_slow_sel = 1'b0;
    logic [1:0]  opt_edges = 2'h0;
    logic [1:0]  opt_guard = 2'h0;
    logic [2:0]  opt_stretch = 3'h0;
    logic        spinning = 1'b1;
    logic        st_mid = 1'b0;
    logic        bz_mid = 1'b0;
    logic [15:0] reading_q;
    logic        stalled_q, slow_q, done_q, stretch_q, busy_q;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cyc_cnt = 0;
    int          t, lo;

    fted_top #(.TICK_DIV(DIV)) dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .fan_speed_input_n(tach),
        .pwm_on(pwm_on), .update_start(update_start),
        .mode_sync(mode_sync), .opt_ignore3(opt_ignore3),
        .opt_slow_sel(opt_slow_sel), .opt_edges(opt_edges),
        .opt_guard(opt_guard), .opt_stretch(opt_stretch),
        .reading_q(reading_q), .stalled_q(stalled_q), .slow_q(slow_q),
        .done_q(done_q), .stretch_q(stretch_q), .busy_q(busy_q));

    fted_fan_model fan (
        .ref_clk(ref_clk), .reset_n(reset_n), .powered(pwm_on | stretch_q),
        .spinning(spinning), .period(16'(PER)), .tach(tach));

    initial begin
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Compare, access and closing tasks
    // ------------------------------------------------------------------
    task automatic cmp16(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", n, e, g);
        end
    endtask : cmp16

    task automatic cmp1(input string n, input logic e, input logic g);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %b got %b", n, e, g);
        end
    endtask : cmp1

    task automatic cmp_rng(input string n, input int l, input int h,
                           input int g);
        tests_run++;
        if (g < l || g > h) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %0d..%0d got %0d", n, l, h, g);
        end
    endtask : cmp_rng

    task automatic end_sim();
        $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : end_sim

    // The PWM is dropped at cycle off_at so that stretching can be seen.
    task automatic wait_done(input int off_at, input int limit,
                             output int cyc);
        cyc = 0;
        while (done_q !== 1'b1 && cyc < limit) begin
            @(negedge ref_clk);
            cyc++;
            if (cyc == off_at) pwm_on = 1'b0;
            if (cyc == off_at + 16) st_mid = stretch_q;
            if (cyc == 16) bz_mid = busy_q;
        end
        cmp1("done", 1'b1, done_q);
    endtask : wait_done

    task automatic sync_run(input logic [1:0] g, input logic [1:0] e,
                            input logic ign, input logic slw,
                            input logic [2:0] str, input int off_at,
                            input int limit, output int cyc);
        repeat (PER) @(negedge ref_clk);
        {opt_guard, opt_edges, opt_ignore3, opt_slow_sel} = {g, e, ign, slw};
        opt_stretch = str;
        update_start = 1'b1;
        pwm_on = 1'b1;
        @(negedge ref_clk);
        update_start = 1'b0;
        wait_done(off_at, limit, cyc);
        cyc++;
        pwm_on = 1'b0;
    endtask : sync_run

    always @(posedge ref_clk) begin
        cyc_cnt++;
        if (cyc_cnt == CYC_LIMIT) begin
            error_cnt++;
            end_sim();
        end
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (12) @(negedge ref_clk);
        cmp16("reading_rst", READ_RESET, reading_q);
        cmp1("stretch_rst", 1'b0, stretch_q);
        reset_n = 1'b1;
        // Guard length per code, with and without the skipped edges.
        for (int g = 0; g < 4; g++) begin
            for (int i = 0; i < 2; i++) begin
                sync_run(2'(g), 2'h0, 1'(i), 1'b0, 3'h0, 0, 3000, t);
                lo = int'(GUARD_TICKS[g]) * DIV + PER * (1 + 3 * i) - 16;
                cmp_rng("meas_time", lo, lo + PER + 40, t);
                cmp16("reading", 16'(PER / DIV), reading_q);
                cmp1("busy_end", 1'b0, busy_q);
                cmp1("busy_mid", 1'b1, bz_mid);
                cmp1("no_stretch", 1'b0, stretch_q);
            end
        end
        // Stalled, then slow with both settings of the select bit.
        for (int k = 0; k < 3; k++) begin
            spinning = (k != 0);
            sync_run(2'h0, 2'h3, 1'b0, k == 2, 3'h0, 360, 3000, t);
            cmp16("class_read", (k == 1) ? READ_SLOW : READ_STALL,
                  reading_q);
            cmp1("stalled", k == 0, stalled_q);
            cmp1("slow", k != 0, slow_q);
        end
        // Short on-time, the stretch keeps the fan powered to the end.
        spinning = 1'b1;
        sync_run(2'h0, 2'h1, 1'b0, 1'b0, 3'h1, 100, 3000, t);
        cmp1("stretch_held", 1'b1, st_mid);
        cmp16("reading_str", 16'(2 * PER / DIV), reading_q);
        cmp1("stretch_end", 1'b0, stretch_q);
        // Stalled fan over a full 50 ms stretch window.
        spinning = 1'b0;
        sync_run(2'h0, 2'h1, 1'b0, 1'b0, 3'h1, 100, 40000, t);
        lo = (8 + int'(16'h1194)) * DIV - 24;
        cmp_rng("stretch_win", lo, lo + 64, t);
        cmp16("stall_str", READ_STALL, reading_q);
        cmp1("stretch_full", 1'b1, st_mid);
        // Continuous mode; the first result after a change is discarded.
        @(negedge ref_clk);
        {mode_sync, pwm_on, spinning, opt_ignore3} = 4'h7;
        for (int e = 0; e < 4; e++) begin
            opt_edges = 2'(e);
            wait_done(0, 3000, t);
            @(negedge ref_clk);
            wait_done(0, 3000, t);
            cmp16("cont_read", 16'((EDGE_COUNT[e] - 1) * PER / DIV),
                  reading_q);
            cmp1("cont_slow", 1'b0, slow_q);
            @(negedge ref_clk);
        end
        end_sim();
    end
endmodule : test_fted_top
